// File: common/sgoc_pkg.sv
// Behaviour
// - safety outputs may only be on while the guard is closed
// - unique mode accepts an actuator only on an exact code match
// - multicode mode accepts any recognisable actuator type, no compare
// - a permissible code for the active scheme releases both channels
// - guard opening drops both channels and the guard-closed indicator
// - any fault forces outputs off, lights lamp, asserts fault output
// - self-checks catch failures at the latest on the next switch-on
// - actuator near range edge raises a separate limit-range warning
// - own test pulses on both outputs, each at most 0.4 ms long
// - read back both output channels continuously against command
package sgoc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int TP_MAX_NS = 400000;
  // longest pulse rounds down
  localparam int TP_MAX_CYC = TP_MAX_NS / CLK_NS;
  localparam int TP_PERIOD_NS = 100000000;
  localparam int TP_PERIOD_CYC = TP_PERIOD_NS / CLK_NS;
  // least settle and check times round up
  localparam int SETTLE_NS = 10000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CHECK_NS = 20000;
  localparam int CHECK_CYC = (CHECK_NS + CLK_NS - 1) / CLK_NS;
  localparam int PCNT_W = 24;
  localparam int CCNT_W = 12;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_CODE = 8'h0c;
  localparam logic [7:0] ADDR_STATE = 8'h10;

  // status and mask bits
  localparam int EV_RELEASE = 0;
  localparam int EV_OPEN = 1;
  localparam int EV_FAULT = 2;
  localparam int EV_LIMIT = 3;
  localparam int EV_REJECT = 4;
  localparam int EV_W = 5;

  // control bits
  localparam int CTRL_MULTI = 0;
  localparam int CTRL_CLEAR = 1;

  // state register fields
  localparam int STV_ST = 0;
  localparam int STV_GUARD = 2;
  localparam int STV_CODE = 3;
  localparam int STV_CAUSE = 4;
  localparam int STV_OUT1 = 7;
  localparam int STV_OUT2 = 8;
  localparam int NCMP = 3;

  localparam logic [EV_W-1:0] MASK_RST = 5'h00;
  localparam logic CTRL_MULTI_RST = 1'h0;

  typedef enum logic [1:0]
  {
    ST_OFF = 2'h0,
    ST_CHECK = 2'h1,
    ST_ON = 2'h3,
    ST_FAULT = 2'h2
  } sgoc_state_e;

endpackage

// File: common/sgoc_chan_if.sv
`timescale 1ns/1ps
// commanded level against read-back level of one compare point
interface sgoc_chan_if;
  logic cmd;
  logic fb;
  logic mism;
  modport ctrl (output cmd, output fb, input mism);
  modport chan (input cmd, input fb, output mism);
endinterface

// File: hdl/sgoc_sync.sv
`timescale 1ns/1ps
module sgoc_sync #(
  parameter int W = 3
)(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sgoc_sync_s;

  sgoc_sync_s s;
  sgoc_sync_s next_s;

  // first stage feeds only the second stage
  always_comb
  begin
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      s <= '0;
    else
      s <= next_s;
  end

  assign q = s.s2;

endmodule

// File: hdl/sgoc_chan.sv
`timescale 1ns/1ps
module sgoc_chan #(
  parameter int SETTLE = sgoc_pkg::SETTLE_CYC
)(
  input wire logic mclk,
  input wire logic nrst,
  sgoc_chan_if.chan ch
);

  typedef struct packed {
    logic [sgoc_pkg::CCNT_W-1:0] cnt;
    logic mism;
  } sgoc_chan_s;

  sgoc_chan_s s;
  sgoc_chan_s next_s;

  // disagreement must outlast the settle time, so pin and
  // synchroniser delay after every edge are not taken as a fault
  always_comb
  begin
    next_s = s;
    if (ch.cmd == ch.fb)
      next_s.cnt = '0;
    else if (s.cnt != sgoc_pkg::CCNT_W'(SETTLE))
      next_s.cnt = s.cnt + 1'b1;
    next_s.mism = (ch.cmd != ch.fb) &&
      (s.cnt == sgoc_pkg::CCNT_W'(SETTLE));
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      s <= '0;
    else
      s <= next_s;
  end

  assign ch.mism = s.mism;

endmodule

// File: hdl/sgoc_top.sv
`timescale 1ns/1ps
module sgoc_top #(
  parameter int CODE_W = 32,
  parameter int TP_WIDTH = sgoc_pkg::TP_MAX_CYC,
  parameter int TP_PERIOD = sgoc_pkg::TP_PERIOD_CYC,
  parameter int SETTLE = sgoc_pkg::SETTLE_CYC,
  parameter int CHECK = sgoc_pkg::CHECK_CYC,
  parameter logic [CODE_W-1:0] CODE_RST = 32'h0000_0000
)(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic guard_closed_pin,
  input wire logic code_strobe,
  input wire logic [CODE_W-1:0] code_data,
  input wire logic code_type_ok,
  input wire logic code_near_edge,
  input wire logic fb_ch1_pin,
  input wire logic fb_ch2_pin,
  input wire logic [sgoc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic safety_out_ch1,
  output logic safety_out_ch2,
  output logic guard_closed_indicator,
  output logic fault_indicator_output,
  output logic diagnostic_lamp,
  output logic limit_warning,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    sgoc_pkg::sgoc_state_e st;
    logic [sgoc_pkg::PCNT_W-1:0] pcnt;
    logic pulse;
    logic [sgoc_pkg::CCNT_W-1:0] ccnt;
    logic code_ok;
    logic lim;
    logic guard_q;
    logic multi;
    logic [CODE_W-1:0] expect_code;
    logic [sgoc_pkg::EV_W-1:0] sts;
    logic [sgoc_pkg::EV_W-1:0] msk;
    logic [sgoc_pkg::NCMP-1:0] cause;
    logic [31:0] rdata;
    logic o1;
    logic o2;
    logic ogc;
    logic ofault;
    logic olamp;
    logic olim;
    logic oirq;
  } sgoc_top_s;

  sgoc_top_s s;
  sgoc_top_s next_s;

  logic [2:0] pin_q;
  logic guard;
  logic fb1;
  logic fb2;
  logic [sgoc_pkg::NCMP-1:0] mism;
  logic flt;
  logic acc;
  logic wr_status;
  logic clr_req;
  logic [sgoc_pkg::EV_W-1:0] clr;
  logic [sgoc_pkg::EV_W-1:0] ev;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  sgoc_sync #(
    .W(3)
  ) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .d({fb_ch2_pin, fb_ch1_pin, guard_closed_pin}),
    .q(pin_q)
  );

  assign guard = pin_q[0];
  assign fb1 = pin_q[1];
  assign fb2 = pin_q[2];

  // ----------------------------------------------------------------
  // read-back comparators: ch1, ch2, ch1 against ch2
  // ----------------------------------------------------------------
  sgoc_chan_if cif[sgoc_pkg::NCMP] ();

  // channel 2 checked against channel 1 catches a split pair
  assign cif[0].cmd = s.o1;
  assign cif[0].fb = fb1;
  assign cif[1].cmd = s.o2;
  assign cif[1].fb = fb2;
  assign cif[2].cmd = fb1;
  assign cif[2].fb = fb2;

  genvar g;
  generate
    for (g = 0; g < sgoc_pkg::NCMP; g++)
    begin : g_cmp
      sgoc_chan #(
        .SETTLE(SETTLE)
      ) u_chan (
        .mclk(mclk),
        .nrst(nrst),
        .ch(cif[g])
      );
      assign mism[g] = cif[g].mism;
    end
  endgenerate

  assign flt = |mism;

  // ----------------------------------------------------------------
  // code judgement
  // ----------------------------------------------------------------
  // multicode only needs a recognisable type, unique needs the value
  always_comb
  begin
    if (s.multi)
      acc = code_type_ok;
    else
      acc = (code_data == s.expect_code);
  end

  // ----------------------------------------------------------------
  // register strobes
  // ----------------------------------------------------------------
  assign wr_status = reg_wr && (reg_addr == sgoc_pkg::ADDR_STATUS);
  assign clr = wr_status ? reg_wdata[sgoc_pkg::EV_W-1:0] : '0;
  assign clr_req = reg_wr && (reg_addr == sgoc_pkg::ADDR_CTRL) &&
    reg_wdata[sgoc_pkg::CTRL_CLEAR];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    ev = '0;
    next_s.guard_q = guard;

    // code latch, dropped as soon as the guard opens
    if (code_strobe)
    begin
      next_s.code_ok = acc && guard;
      next_s.lim = code_near_edge && acc;
      ev[sgoc_pkg::EV_REJECT] = !acc;
      ev[sgoc_pkg::EV_LIMIT] = code_near_edge && acc;
    end
    if (!guard)
    begin
      next_s.code_ok = 1'b0;
      next_s.lim = 1'b0;
    end
    if (s.guard_q && !guard)
      ev[sgoc_pkg::EV_OPEN] = 1'b1;

    // output state machine
    case (s.st)
      sgoc_pkg::ST_OFF:
      begin
        next_s.pcnt = '0;
        next_s.ccnt = '0;
        // readback stuck high while off is caught here too
        if (flt)
          next_s.st = sgoc_pkg::ST_FAULT;
        else if (guard && s.code_ok)
          next_s.st = sgoc_pkg::ST_CHECK;
      end
      sgoc_pkg::ST_CHECK:
      begin
        // self-check window before every switch-on: outputs held off,
        // all compare points must agree for the whole window
        if (flt)
          next_s.st = sgoc_pkg::ST_FAULT;
        else if (!guard || !s.code_ok)
          next_s.st = sgoc_pkg::ST_OFF;
        else if (s.ccnt == sgoc_pkg::CCNT_W'(CHECK - 1))
        begin
          next_s.st = sgoc_pkg::ST_ON;
          ev[sgoc_pkg::EV_RELEASE] = 1'b1;
        end
        else
          next_s.ccnt = s.ccnt + 1'b1;
      end
      sgoc_pkg::ST_ON:
      begin
        if (s.pcnt == sgoc_pkg::PCNT_W'(TP_PERIOD - 1))
          next_s.pcnt = '0;
        else
          next_s.pcnt = s.pcnt + 1'b1;
        if (flt)
          next_s.st = sgoc_pkg::ST_FAULT;
        else if (!guard || !s.code_ok)
          next_s.st = sgoc_pkg::ST_OFF;
      end
      sgoc_pkg::ST_FAULT:
      begin
        next_s.pcnt = '0;
        next_s.ccnt = '0;
        // leave only with the guard open, forcing a fresh check
        if (clr_req && !guard)
          next_s.st = sgoc_pkg::ST_OFF;
      end
      default:
        next_s.st = sgoc_pkg::ST_FAULT;
    endcase

    if (next_s.st == sgoc_pkg::ST_FAULT && s.st != sgoc_pkg::ST_FAULT)
    begin
      ev[sgoc_pkg::EV_FAULT] = 1'b1;
      next_s.cause = mism;
    end

    // test pulse sits at the end of each period, the read-back of
    // the low level is checked by the same comparators
    next_s.pulse = (next_s.st == sgoc_pkg::ST_ON) &&
      (next_s.pcnt >= sgoc_pkg::PCNT_W'(TP_PERIOD - TP_WIDTH));

    // outputs need closed guard and the on state
    next_s.o1 = (next_s.st == sgoc_pkg::ST_ON) && guard &&
      !next_s.pulse;
    next_s.o2 = (next_s.st == sgoc_pkg::ST_ON) && guard &&
      !next_s.pulse;
    next_s.ogc = guard;
    next_s.ofault = (next_s.st == sgoc_pkg::ST_FAULT);
    next_s.olamp = (next_s.st == sgoc_pkg::ST_FAULT);
    next_s.olim = next_s.lim;

    // register writes
    if (reg_wr)
    begin
      case (reg_addr)
        sgoc_pkg::ADDR_MASK:
          next_s.msk = reg_wdata[sgoc_pkg::EV_W-1:0];
        sgoc_pkg::ADDR_CTRL:
          next_s.multi = reg_wdata[sgoc_pkg::CTRL_MULTI];
        sgoc_pkg::ADDR_CODE:
          next_s.expect_code = reg_wdata[CODE_W-1:0];
        default:
          next_s.st = next_s.st;
      endcase
    end

    // sticky events, a set in the clearing cycle survives
    next_s.sts = (s.sts & ~clr) | ev;
    next_s.oirq = |(next_s.sts & next_s.msk);

    // read data for the cycle after the strobe only
    next_s.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        sgoc_pkg::ADDR_STATUS:
          next_s.rdata[sgoc_pkg::EV_W-1:0] = s.sts;
        sgoc_pkg::ADDR_MASK:
          next_s.rdata[sgoc_pkg::EV_W-1:0] = s.msk;
        sgoc_pkg::ADDR_CTRL:
          next_s.rdata[sgoc_pkg::CTRL_MULTI] = s.multi;
        sgoc_pkg::ADDR_CODE:
          next_s.rdata[CODE_W-1:0] = s.expect_code;
        sgoc_pkg::ADDR_STATE:
        begin
          next_s.rdata[sgoc_pkg::STV_ST +: 2] = s.st;
          next_s.rdata[sgoc_pkg::STV_GUARD] = guard;
          next_s.rdata[sgoc_pkg::STV_CODE] = s.code_ok;
          next_s.rdata[sgoc_pkg::STV_CAUSE +: sgoc_pkg::NCMP] = s.cause;
          next_s.rdata[sgoc_pkg::STV_OUT1] = s.o1;
          next_s.rdata[sgoc_pkg::STV_OUT2] = s.o2;
        end
        default:
          next_s.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s <= '0;
      s.st <= sgoc_pkg::ST_OFF;
      s.msk <= sgoc_pkg::MASK_RST;
      s.multi <= sgoc_pkg::CTRL_MULTI_RST;
      s.expect_code <= CODE_RST;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // outputs straight from flops
  // ----------------------------------------------------------------
  assign reg_rdata = s.rdata;
  assign safety_out_ch1 = s.o1;
  assign safety_out_ch2 = s.o2;
  assign guard_closed_indicator = s.ogc;
  assign fault_indicator_output = s.ofault;
  assign diagnostic_lamp = s.olamp;
  assign limit_warning = s.olim;
  assign irq = s.oirq;

endmodule

// File: bench/sgoc_monitor.sv
`timescale 1ns/1ps
module sgoc_monitor #(
  parameter int TP_WIDTH = 40
)(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic safety_out_ch1,
  input wire logic safety_out_ch2,
  input wire logic guard_closed_indicator,
  input wire logic fault_indicator_output,
  input wire logic diagnostic_lamp,
  input wire logic limit_warning,
  input wire logic fb_ch1_pin,
  input wire logic fb_ch2_pin
);
  // ------------------------------------------------------------
  // output rules
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  property p_closed;
    safety_out_ch1 || safety_out_ch2 |-> guard_closed_indicator;
  endproperty
  a_closed: assert property (p_closed)
    else $error("output on with guard open");
  // both channels always switch as a pair
  property p_pair;
    safety_out_ch1 == safety_out_ch2;
  endproperty
  a_pair: assert property (p_pair)
    else $error("channels disagree");
  property p_fault_off;
    fault_indicator_output |-> !safety_out_ch1 && !safety_out_ch2;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("output on during fault");
  property p_lamp;
    diagnostic_lamp == fault_indicator_output;
  endproperty
  a_lamp: assert property (p_lamp)
    else $error("lamp and fault output differ");
  property p_open;
    $fell(guard_closed_indicator) |-> !safety_out_ch1 && !safety_out_ch2;
  endproperty
  a_open: assert property (p_open)
    else $error("output kept on at guard open");
  property p_limit;
    $fell(guard_closed_indicator) |=> !limit_warning;
  endproperty
  a_limit: assert property (p_limit)
    else $error("limit warning kept after open");
  // a drop not caused by fault or open must end within the pulse limit
  property p_pulse;
    $fell(safety_out_ch1) |-> ##[1:TP_WIDTH] (safety_out_ch1 ||
      fault_indicator_output || !guard_closed_indicator);
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("test pulse too long");
  // the partner lags by at most five edges, so eight is a real fault
  property p_readback;
    ((safety_out_ch1 != fb_ch1_pin) || (safety_out_ch2 != fb_ch2_pin))[*8]
      |-> ##[0:12] fault_indicator_output;
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback mismatch not faulted");
endmodule

// File: bench/sgoc_partner.sv
`timescale 1ns/1ps
module sgoc_partner (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic safety_out_ch1,
  input wire logic safety_out_ch2,
  input wire logic slow,
  input wire logic err1,
  input wire logic err2,
  output logic fb_ch1_pin,
  output logic fb_ch2_pin,
  output logic [15:0] gap
);
  logic [4:0] d1;
  logic [4:0] d2;
  logic [15:0] cnt;
  // read-back lag and low-run length; no own pulsing on the lines
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      d1 <= '0;
      d2 <= '0;
      cnt <= '0;
      gap <= '0;
    end
    else
    begin
      d1 <= {d1[3:0], safety_out_ch1};
      d2 <= {d2[3:0], safety_out_ch2};
      cnt <= safety_out_ch1 ? 16'h0 : cnt + 16'h1;
      if (safety_out_ch1 && cnt != 16'h0)
        gap <= cnt;
    end
  end
  // err lines break the read-back only where a scenario asks
  assign fb_ch1_pin = err1 | (slow ? d1[4] : d1[0]);
  assign fb_ch2_pin = !err2 & (slow ? d2[4] : d2[0]);
endmodule

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int TPW = 40;
  localparam int CHK = 16;
  logic mclk = 0;
  logic nrst = 0;
  logic guard_closed_pin = 0;
  logic code_strobe = 0;
  logic [31:0] code_data = '0;
  logic code_type_ok = 0;
  logic code_near_edge = 0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic slow = 0;
  logic err1 = 0;
  logic err2 = 0;
  logic fb_ch1_pin, fb_ch2_pin, safety_out_ch1, safety_out_ch2;
  logic guard_closed_indicator, fault_indicator_output, diagnostic_lamp;
  logic limit_warning, irq;
  logic [31:0] reg_rdata;
  logic [15:0] gap;
  logic [31:0] code;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 76094;
  int n;
  always #25 mclk = ~mclk;
  sgoc_top #(.TP_PERIOD(200), .TP_WIDTH(TPW), .SETTLE(8), .CHECK(CHK)) dut (
    .mclk, .nrst, .guard_closed_pin, .code_strobe, .code_data,
    .code_type_ok, .code_near_edge, .fb_ch1_pin, .fb_ch2_pin, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .safety_out_ch1,
    .safety_out_ch2, .guard_closed_indicator, .fault_indicator_output,
    .diagnostic_lamp, .limit_warning, .irq);
  sgoc_partner u_partner (.mclk, .nrst, .safety_out_ch1, .safety_out_ch2,
    .slow, .err1, .err2, .fb_ch1_pin, .fb_ch2_pin, .gap);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic strobe(input logic [31:0] c, input logic t, input logic e);
    @(posedge mclk);
    code_strobe <= 1'b1;
    code_data <= c;
    code_type_ok <= t;
    code_near_edge <= e;
    @(posedge mclk);
    code_strobe <= 1'b0;
  endtask
  task automatic set_guard(input logic v);
    @(posedge mclk);
    guard_closed_pin <= v;
    tick(6);
  endtask
  // bounded waits, n counts edges taken
  task automatic wait_on;
    for (n = 0; safety_out_ch1 !== 1'b1 && n < 400; n++)
      tick(1);
  endtask
  task automatic wait_fault;
    for (n = 0; fault_indicator_output !== 1'b1 && n < 60; n++)
      tick(1);
  endtask
  function automatic logic [31:0] ev(input int b);
    return 32'h1 << b;
  endfunction
  function automatic logic [31:0] st_word(input logic [1:0] s,
    input logic g, input logic c, input logic o);
    return {23'h0, o, o, 3'h0, c, g, s};
  endfunction
  // a hang counts as a mismatch and ends the run
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      num_errors++;
      conclude;
    end
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    tick(1);
    chk({safety_out_ch1, safety_out_ch2, fault_indicator_output, irq}, 0);
    rd_chk(sgoc_pkg::ADDR_MASK, 0);
    rd_chk(sgoc_pkg::ADDR_CTRL, 0);
    rd_chk(sgoc_pkg::ADDR_CODE, 0);
    rd_chk(sgoc_pkg::ADDR_STATE, 0);
    rd_chk(8'h14, 0);
    code = $random(seed);
    wr_reg(sgoc_pkg::ADDR_MASK, 32'h1f);
    wr_reg(sgoc_pkg::ADDR_CODE, code);
    wr_reg(8'h14, 32'hffff_ffff);
    rd_chk(sgoc_pkg::ADDR_CODE, code);
    set_guard(1);
    chk(guard_closed_indicator, 1);
    // one bit off the expected code must be refused
    strobe(code ^ ev($random(seed) & 31), 1, 0);
    tick(CHK + 8);
    chk(safety_out_ch1, 0);
    rd_chk(sgoc_pkg::ADDR_STATUS, ev(sgoc_pkg::EV_REJECT));
    chk(irq, 1);
    wr_reg(sgoc_pkg::ADDR_MASK, 0);
    tick(2);
    chk(irq, 0);
    wr_reg(sgoc_pkg::ADDR_MASK, 32'h1f);
    tick(2);
    chk(irq, 1);
    wr_reg(sgoc_pkg::ADDR_STATUS, ev(sgoc_pkg::EV_REJECT));
    tick(2);
    chk(irq, 0);
    strobe(code, 0, 1);
    wait_on;
    chk(n, CHK + 1);
    chk(limit_warning, 1);
    rd_chk(sgoc_pkg::ADDR_STATE, st_word(2'h3, 1, 1, 1));
    rd_chk(sgoc_pkg::ADDR_STATUS, ev(0) | ev(3));
    // wait through one test pulse and measure it downstream
    for (n = 0; safety_out_ch1 === 1'b1 && n < 400; n++)
      tick(1);
    wait_on;
    tick(1);
    chk(gap, TPW);
    set_guard(0);
    chk({safety_out_ch1, guard_closed_indicator, limit_warning}, 0);
    rd_chk(sgoc_pkg::ADDR_STATUS, ev(0) | ev(1) | ev(3));
    strobe(code, 1, 0);
    tick(CHK + 8);
    chk(safety_out_ch1, 0);
    wr_reg(sgoc_pkg::ADDR_STATUS, 32'h1f);
    // multicode with a slow read-back
    wr_reg(sgoc_pkg::ADDR_CTRL, ev(sgoc_pkg::CTRL_MULTI));
    @(posedge mclk);
    slow <= 1'b1;
    set_guard(1);
    strobe($random(seed), 0, 0);
    tick(CHK + 8);
    chk(safety_out_ch1, 0);
    rd_chk(sgoc_pkg::ADDR_STATUS, ev(sgoc_pkg::EV_REJECT));
    wr_reg(sgoc_pkg::ADDR_STATUS, 32'h1f);
    strobe($random(seed), 1, 0);
    wait_on;
    chk(n, CHK + 1);
    // channel two read-back dies while on
    @(posedge mclk);
    err2 <= 1'b1;
    wait_fault;
    chk({fault_indicator_output, diagnostic_lamp, safety_out_ch1}, 6);
    rd_chk(sgoc_pkg::ADDR_STATUS, ev(0) | ev(2));
    @(posedge mclk);
    err2 <= 1'b0;
    wr_reg(sgoc_pkg::ADDR_CTRL, 32'h3);
    tick(4);
    chk(fault_indicator_output, 1);
    set_guard(0);
    wr_reg(sgoc_pkg::ADDR_CTRL, ev(sgoc_pkg::CTRL_CLEAR));
    tick(4);
    chk({fault_indicator_output, diagnostic_lamp}, 0);
    // stuck read-back caught before any switch-on
    @(posedge mclk);
    err1 <= 1'b1;
    wait_fault;
    chk(fault_indicator_output, 1);
    @(posedge mclk);
    err1 <= 1'b0;
    // let the synchronised read-back settle, else the clear re-faults
    tick(4);
    wr_reg(sgoc_pkg::ADDR_CTRL, ev(sgoc_pkg::CTRL_CLEAR));
    tick(4);
    chk(fault_indicator_output, 0);
    conclude;
  end
endmodule
bind sgoc_top sgoc_monitor #(.TP_WIDTH(TP_WIDTH)) u_mon (
  .mclk,
  .nrst,
  .safety_out_ch1,
  .safety_out_ch2,
  .guard_closed_indicator,
  .fault_indicator_output,
  .diagnostic_lamp,
  .limit_warning,
  .fb_ch1_pin,
  .fb_ch2_pin
);
